// [rtl/synth_one_ctrl.v]
// Serial control words of synthesizer one and output select logic.
// Assumes a host drives data, clock and load strobe pins asynchronously;
// divider and lock signals arrive from logic on mclk_in.
//
// Summary of operation
// RULE_01 - Reference ratio in reference bits 2 to 16
// RULE_02 - Host never loads reference ratio below 3
// RULE_03 - Reference bit 17 sets detector polarity
// RULE_04 - Reference bit 18 selects pump current level
// RULE_05 - Reference bit 19 floats pump output immediately
// RULE_06 - Float and power bits decoded together
// RULE_07 - Combinations: normal, float, sync, async powerdown
// RULE_08 - Swallow count in feedback bits 2 to 8
// RULE_09 - Swallow count accepts 0 to 127
// RULE_10 - Binary count in feedback bits 9 to 19
// RULE_11 - Host keeps binary count 3 to 2047
// RULE_12 - Feedback bit 20 selects prescaler ratio
// RULE_13 - Feedback bit 21 powers synthesizer down
// RULE_14 - Select built from both reference words
// RULE_15 - One internal signal routed to pin
// RULE_16 - Select 0000 drives pin low
// RULE_17 - Divider codes drive pin push-pull
// RULE_18 - Select 0011 gives open-drain fastlock
// RULE_19 - Lock codes drive lock detect push-pull
// RULE_20 - Reset codes drive low, hold counters
// RULE_21 - 22-bit frame, MSB first, address last
// RULE_22 - Load strobe rise copies data to word
// RULE_23 - Address picks one of four words
// RULE_24 - Host keeps binary count not below swallow
// RULE_25 - Words hold until addressed again
`timescale 1ns/10ps
`default_nettype none
`include "synth_ctrl_defines.vh"
module synth_one_ctrl (
	input  wire        mclk_in,
	input  wire        rst_n_in,
	input  wire        serial_data_in,
	input  wire        serial_clk_in,
	input  wire        load_strobe_in,
	input  wire        two_ref_div_in,
	input  wire        one_ref_div_in,
	input  wire        two_fb_div_in,
	input  wire        one_fb_div_in,
	input  wire        two_lock_in,
	input  wire        one_lock_in,
	input  wire        fastlock_in,
	output reg  [14:0] reference_divide_ratio_out,
	output reg         phase_detector_polarity_out,
	output reg         pump_current_level_out,
	output reg         pump_float_control_out,
	output reg  [6:0]  swallow_count_out,
	output reg  [10:0] feedback_binary_count_out,
	output reg         prescaler_ratio_select_out,
	output reg         synth_power_off_out,
	output reg         sync_powerdown_out,
	output reg         async_powerdown_out,
	output reg  [3:0]  multi_function_output_select_out,
	output reg         mfo_pin_out,
	output reg         mfo_pin_oe_n_out,
	output reg         synth_one_counter_reset_out,
	output reg         synth_two_counter_reset_out
);
	localparam MODE_ACTIVE = 4'h1;   // One-hot operating modes
	localparam MODE_FLOAT  = 4'h2;
	localparam MODE_SYNC   = 4'h4;
	localparam MODE_ASYNC  = 4'h8;

	wire [2:0]  pins_sync;           // Synchronised data, clock, strobe
	reg         clk_prev_r;          // Last sampled link clock level
	reg         le_prev_r;           // Last sampled strobe level
	reg  [21:0] shift_r;             // Incoming frame
	reg  [21:0] synth_one_reference_word_r;
	reg  [21:0] synth_one_feedback_word_r;
	reg  [1:0]  two_sel_bits_r;      // Select bits held in second ref word
	reg  [3:0]  mode_nxt;            // Decoded operating mode
	reg  [3:0]  sel_nxt;             // Assembled output select
	reg         pin_nxt;             // Pin level for current select
	reg         oe_n_nxt;            // Pin enable, low drives
	wire        clk_rise;            // Link clock rising edge
	wire        le_rise;             // Load strobe rising edge

	// Bring the three link pins into the clock domain
	link_sync #(
		.WIDTH(3)
	) u_sync (
		.mclk_in (mclk_in),
		.rst_n_in(rst_n_in),
		.async_in({serial_data_in, serial_clk_in, load_strobe_in}),
		.sync_out(pins_sync)
	);

	assign clk_rise = pins_sync[1] & ~clk_prev_r;
	assign le_rise  = pins_sync[0] & ~le_prev_r;

	// Decode float and powerdown bits into one mode
	function [3:0] mode_of;
		input float_bit;
		input power_bit;
		begin
			case ({float_bit, power_bit})   // [RULE_06] [RULE_07]
			2'b00:   mode_of = MODE_ACTIVE;
			2'b10:   mode_of = MODE_FLOAT;
			2'b01:   mode_of = MODE_SYNC;
			default: mode_of = MODE_ASYNC;
			endcase
		end
	endfunction

	// Shift frame on clock edges, load word on strobe edges
	always @(posedge mclk_in) begin
		if (!rst_n_in) begin
			clk_prev_r                 <= 1'b0;
			le_prev_r                  <= 1'b0;
			shift_r                    <= `WORD_RESET;
			synth_one_reference_word_r <= `WORD_RESET;
			synth_one_feedback_word_r  <= `WORD_RESET;
			two_sel_bits_r             <= 2'h0;
		end else begin
			clk_prev_r <= pins_sync[1];
			le_prev_r  <= pins_sync[0];
			if (clk_rise) begin
				// MSB enters first and ends in bit 21
				shift_r <= {shift_r[20:0], pins_sync[2]};   // [RULE_21]
			end
			if (le_rise) begin
				// Only the addressed word changes [RULE_25]
				case (shift_r[1:0])   // [RULE_22] [RULE_23]
				`ADDR_SYNTH_ONE_REF: begin
					synth_one_reference_word_r <= shift_r;
				end
				`ADDR_SYNTH_ONE_FB: begin
					synth_one_feedback_word_r <= shift_r;
				end
				`ADDR_SYNTH_TWO_REF: begin
					two_sel_bits_r <= {shift_r[`REF_SEL_HI_BIT],
						shift_r[`REF_SEL_LO_BIT]};
				end
				default: begin
					// Second feedback word: fields not kept here
				end
				endcase
			end
		end
	end

	// Assemble select, pick mode and pin behaviour
	always @* begin
		mode_nxt = mode_of(synth_one_reference_word_r[`REF_FLOAT_BIT],
			synth_one_feedback_word_r[`FB_POWER_BIT]);
		sel_nxt = {synth_one_reference_word_r[`REF_SEL_HI_BIT],
			two_sel_bits_r[1],
			synth_one_reference_word_r[`REF_SEL_LO_BIT],
			two_sel_bits_r[0]};   // [RULE_14]
		pin_nxt  = 1'b0;
		oe_n_nxt = 1'b0;
		case (sel_nxt)   // [RULE_15]
		`SEL_LOW:       pin_nxt = 1'b0;   // [RULE_16]
		4'h1, 4'h9:     pin_nxt = two_ref_div_in;   // [RULE_17]
		4'h2, 4'ha:     pin_nxt = one_ref_div_in;   // [RULE_17]
		4'h5, 4'hd:     pin_nxt = two_fb_div_in;    // [RULE_17]
		4'h6, 4'he:     pin_nxt = one_fb_div_in;    // [RULE_17]
		`SEL_FASTLOCK: begin
			// Open drain: pull low only when fastlock asserts
			pin_nxt  = 1'b0;
			oe_n_nxt = ~fastlock_in;   // [RULE_18]
		end
		`SEL_LOCK_TWO:  pin_nxt = two_lock_in;      // [RULE_19]
		`SEL_LOCK_ONE:  pin_nxt = one_lock_in;      // [RULE_19]
		`SEL_LOCK_BOTH: pin_nxt = one_lock_in & two_lock_in; // [RULE_19]
		default:        pin_nxt = 1'b0;   // Reset codes drive low [RULE_20]
		endcase
	end

	// Register all outputs from the held words and the pin inputs
	always @(posedge mclk_in) begin
		if (!rst_n_in) begin
			reference_divide_ratio_out       <= 15'h0000;
			phase_detector_polarity_out      <= 1'b0;
			pump_current_level_out           <= 1'b0;
			pump_float_control_out           <= 1'b0;
			swallow_count_out                <= 7'h00;
			feedback_binary_count_out        <= 11'h000;
			prescaler_ratio_select_out       <= 1'b0;
			synth_power_off_out              <= 1'b0;
			sync_powerdown_out               <= 1'b0;
			async_powerdown_out              <= 1'b0;
			multi_function_output_select_out <= 4'h0;
			mfo_pin_out                      <= 1'b0;
			mfo_pin_oe_n_out                 <= 1'b0;
			synth_one_counter_reset_out      <= 1'b0;
			synth_two_counter_reset_out      <= 1'b0;
		end else begin
			reference_divide_ratio_out <= synth_one_reference_word_r
				[`REF_RATIO_MSB:`REF_RATIO_LSB];   // [RULE_01]
			phase_detector_polarity_out <=
				synth_one_reference_word_r[`REF_POL_BIT];   // [RULE_03]
			pump_current_level_out <=
				synth_one_reference_word_r[`REF_PUMP_BIT];  // [RULE_04]
			// Follows the word at once, no divider event awaited
			pump_float_control_out <=
				synth_one_reference_word_r[`REF_FLOAT_BIT]; // [RULE_05]
			swallow_count_out <= synth_one_feedback_word_r
				[`FB_SWALLOW_MSB:`FB_SWALLOW_LSB];   // [RULE_08] [RULE_09]
			feedback_binary_count_out <= synth_one_feedback_word_r
				[`FB_BINARY_MSB:`FB_BINARY_LSB];     // [RULE_10]
			prescaler_ratio_select_out <=
				synth_one_feedback_word_r[`FB_PRESCALE_BIT]; // [RULE_12]
			synth_power_off_out <=
				synth_one_feedback_word_r[`FB_POWER_BIT];    // [RULE_13]
			sync_powerdown_out  <= mode_nxt[2];   // [RULE_07]
			async_powerdown_out <= mode_nxt[3];   // [RULE_07]
			multi_function_output_select_out <= sel_nxt;
			mfo_pin_out      <= pin_nxt;
			mfo_pin_oe_n_out <= oe_n_nxt;
			synth_one_counter_reset_out <= (sel_nxt == `SEL_RST_ONE) |
				(sel_nxt == `SEL_RST_ALL);   // [RULE_20]
			synth_two_counter_reset_out <= (sel_nxt == `SEL_RST_TWO) |
				(sel_nxt == `SEL_RST_ALL);   // [RULE_20]
		end
	end
endmodule
`default_nettype wire

// [rtl/synth_ctrl_defines.vh]
// Constants for the serial control words and output select.
// Assumes inclusion by bare name from the design files.
`ifndef SYNTH_CTRL_DEFINES_VH
`define SYNTH_CTRL_DEFINES_VH
`define FRAME_BITS        22
`define ADDR_SYNTH_TWO_REF 2'h0
`define ADDR_SYNTH_TWO_FB  2'h1
`define ADDR_SYNTH_ONE_REF 2'h2
`define ADDR_SYNTH_ONE_FB  2'h3
`define REF_RATIO_LSB     2
`define REF_RATIO_MSB     16
`define REF_POL_BIT       17
`define REF_PUMP_BIT      18
`define REF_FLOAT_BIT     19
`define REF_SEL_HI_BIT    20
`define REF_SEL_LO_BIT    21
`define FB_SWALLOW_LSB    2
`define FB_SWALLOW_MSB    8
`define FB_BINARY_LSB     9
`define FB_BINARY_MSB     19
`define FB_PRESCALE_BIT   20
`define FB_POWER_BIT      21
`define WORD_RESET        22'h000000
`define SEL_LOW           4'h0
`define SEL_FASTLOCK      4'h3
`define SEL_LOCK_TWO      4'h4
`define SEL_LOCK_ONE      4'h8
`define SEL_LOCK_BOTH     4'hc
`define SEL_RST_TWO       4'h7
`define SEL_RST_ONE       4'hb
`define SEL_RST_ALL       4'hf
`endif

// [rtl/link_sync.v]
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to mclk_in.
`timescale 1ns/10ps
`default_nettype none
module link_sync #(
	parameter WIDTH = 3
) (
	input  wire             mclk_in,
	input  wire             rst_n_in,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_r;   // First stage, read only by second stage

	// Two stages; first feeds nothing but the second
	always @(posedge mclk_in) begin
		if (!rst_n_in) begin
			meta_r   <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// [test/synth_one_ctrl_assertions.sv]
// Checker for the output select pin and control word update timing.
// Assumes it is bound to synth_one_ctrl and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module synth_one_ctrl_assertions (
	input wire        mclk_in,
	input wire        rst_n_in,
	input wire        load_strobe_in,
	input wire        one_ref_div_in,
	input wire        one_fb_div_in,
	input wire        two_lock_in,
	input wire        one_lock_in,
	input wire        fastlock_in,
	input wire [14:0] reference_divide_ratio_out,
	input wire [6:0]  swallow_count_out,
	input wire [10:0] feedback_binary_count_out,
	input wire        synth_power_off_out,
	input wire        sync_powerdown_out,
	input wire        async_powerdown_out,
	input wire [3:0]  multi_function_output_select_out,
	input wire        mfo_pin_out,
	input wire        mfo_pin_oe_n_out
);
	// Short alias of the select code
	wire [3:0] s = multi_function_output_select_out;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	// Select and pin leave the same register stage, so they are compared
	// in the same cycle; the pin shows the input of the cycle before
	property p_pp; s != 4'h3 |-> !mfo_pin_oe_n_out; endproperty
	a_pp: assert property (p_pp) else $error("pin released");
	property p_low; s == 4'h0 |-> !mfo_pin_out; endproperty
	a_low: assert property (p_low) else $error("pin not low");
	property p_rst; s[1:0] == 2'h3 && s[3:2] != 2'h0 |-> !mfo_pin_out;
	endproperty
	a_rst: assert property (p_rst) else $error("reset code pin");
	property p_fast;
		s == 4'h3 |-> !mfo_pin_out && mfo_pin_oe_n_out == !$past(fastlock_in);
	endproperty
	a_fast: assert property (p_fast) else $error("fastlock pin");
	property p_rdiv; s[2:0] == 3'h2 |-> mfo_pin_out == $past(one_ref_div_in);
	endproperty
	a_rdiv: assert property (p_rdiv) else $error("ref div pin");
	property p_ndiv; s[2:0] == 3'h6 |-> mfo_pin_out == $past(one_fb_div_in);
	endproperty
	a_ndiv: assert property (p_ndiv) else $error("fb div pin");
	property p_lock; s == 4'h8 |-> mfo_pin_out == $past(one_lock_in);
	endproperty
	a_lock: assert property (p_lock) else $error("lock pin");
	property p_both;
		s == 4'hc |-> mfo_pin_out == $past(one_lock_in && two_lock_in);
	endproperty
	a_both: assert property (p_both) else $error("both lock pin");
	property p_hold;
		$changed({reference_divide_ratio_out, swallow_count_out,
			feedback_binary_count_out, synth_power_off_out})
			|-> $past(load_strobe_in, 3);
	endproperty
	a_hold: assert property (p_hold) else $error("word moved");
	property p_pd; async_powerdown_out |-> !sync_powerdown_out; endproperty
	a_pd: assert property (p_pd) else $error("powerdown modes");
endmodule
bind synth_one_ctrl synth_one_ctrl_assertions u_synth_one_ctrl_assertions (
	.mclk_in, .rst_n_in, .load_strobe_in, .one_ref_div_in, .one_fb_div_in,
	.two_lock_in, .one_lock_in, .fastlock_in, .reference_divide_ratio_out,
	.swallow_count_out, .feedback_binary_count_out, .synth_power_off_out,
	.sync_powerdown_out, .async_powerdown_out,
	.multi_function_output_select_out, .mfo_pin_out, .mfo_pin_oe_n_out);
`default_nettype wire

// [test/serial_host.sv]
// Host model that shifts 22-bit frames over the three-wire link.
// Assumes the link runs at 125 ns and stands still between frames.
`timescale 1ns/10ps
`default_nettype none
module serial_host (
	input  wire logic mclk_in,
	output var  logic sdata_out,
	output var  logic sclk_out,
	output var  logic strobe_out
);
	// Link idles low with strobe low
	initial begin
		sdata_out = 0;
		sclk_out = 0;
		strobe_out = 0;
	end
	// Shift MSB first, then raise the strobe with the clock quiet
	task send(input logic [21:0] f);
		int i;
		@(posedge mclk_in);
		#1;
		for (i = 21; i >= 0; i--) begin
			sdata_out = f[i];
			#62.5 sclk_out = 1;
			#62.5 sclk_out = 0;
		end
		sdata_out = ~f[0]; // Line then carries the inverse of bit 0, not a stale bit
		#20 strobe_out = 1;
		#80 strobe_out = 0;
		#20;
	endtask
endmodule
`default_nettype wire

// [test/synth_one_ctrl_test.sv]
// Self-checking bench for the synthesizer one control words.
// Assumes serial_host drives the link and the checker is bound.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
	$display("[ERR] %0t mismatch %h %h", $time, a, e); end end
module synth_one_ctrl_test;
	logic mclk_in = 0, rst_n_in = 0;
	logic [6:0] aux = 0; // Divider and lock stimulus
	int error_cnt = 0, compares = 0;
	wire sd, sc, le, pol, pump, flt, pre, pwr, spd, apd, pin, oe_n, r1, r2;
	wire [14:0] ratio;
	wire [6:0] swc;
	wire [10:0] bin;
	wire [3:0] sel;
	always #5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) #1 aux <= aux + 7'h1;
	serial_host u_serial_host (.mclk_in(mclk_in), .sdata_out(sd),
		.sclk_out(sc), .strobe_out(le));
	synth_one_ctrl u_synth_one_ctrl (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.serial_data_in(sd), .serial_clk_in(sc), .load_strobe_in(le),
		.two_ref_div_in(aux[0]), .one_ref_div_in(aux[1]),
		.two_fb_div_in(aux[2]), .one_fb_div_in(aux[3]), .two_lock_in(aux[4]),
		.one_lock_in(aux[5]), .fastlock_in(aux[6]),
		.reference_divide_ratio_out(ratio), .phase_detector_polarity_out(pol),
		.pump_current_level_out(pump), .pump_float_control_out(flt),
		.swallow_count_out(swc), .feedback_binary_count_out(bin),
		.prescaler_ratio_select_out(pre), .synth_power_off_out(pwr),
		.sync_powerdown_out(spd), .async_powerdown_out(apd),
		.multi_function_output_select_out(sel), .mfo_pin_out(pin),
		.mfo_pin_oe_n_out(oe_n), .synth_one_counter_reset_out(r1),
		.synth_two_counter_reset_out(r2));
	// Prints counts and verdict, then stops
	task end_of_test;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Cuts a hang short
	initial begin
		#300000 error_cnt++;
		end_of_test();
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge mclk_in);
		#1 rst_n_in = 1;
		repeat (3) @(posedge mclk_in);
		`CHK({ratio, pol, pump, flt, swc, bin, pre, pwr, sel, oe_n}, 0)
		$display("reset test done");
		u_serial_host.send({5'b01101, 15'd3, 2'b10});
		`CHK({flt, pump, pol, ratio}, {3'b101, 15'd3})
		u_serial_host.send({2'b11, 11'd2047, 7'd127, 2'b11});
		`CHK({pwr, pre, bin, swc}, {2'b11, 11'd2047, 7'd127})
		`CHK({apd, spd, ratio}, {2'b10, 15'd3})
		u_serial_host.send({5'b00010, 15'h7fff, 2'b10});
		`CHK({flt, pump, pol, ratio}, {3'b010, 15'h7fff})
		`CHK({apd, spd}, 2'b01)
		u_serial_host.send(22'h3ffffd);
		`CHK({ratio, pwr, bin}, {15'h7fff, 1'b1, 11'd2047})
		u_serial_host.send({2'b00, 11'd3, 7'd0, 2'b11});
		`CHK({pwr, pre, bin, swc, apd, spd}, {2'b00, 11'd3, 7'd0, 2'b00})
		$display("word test done");
		for (int i = 0; i < 16; i++) begin
			u_serial_host.send({i[1], i[3], 3'b000, 15'd5, 2'b10});
			u_serial_host.send({i[0], i[2], 18'h0, 2'b00});
			`CHK(sel, i[3:0])
			`CHK({r1, r2}, {i == 11 || i == 15, i == 7 || i == 15})
			`CHK({ratio, bin}, {15'd5, 11'd3})
		end
		$display("select test done");
		end_of_test();
	end
endmodule
`default_nettype wire
